// file: hw/cdrp_pkg.sv
// package: constants and types of the codec direct register port
package cdrp_pkg;
  // direct register selects
  localparam logic [1:0] REG_INDEX_CONTROL  = 2'h0;
  localparam logic [1:0] REG_INDEXED_WINDOW = 2'h1;
  localparam logic [1:0] REG_STATUS_FLAGS   = 2'h2;
  localparam logic [1:0] REG_PIO_DATA       = 2'h3;
  // index_control fields
  localparam int         IDX_INIT_BIT       = 7;
  localparam int         IDX_MCE_BIT        = 6;
  localparam int         IDX_TRD_BIT        = 5;
  localparam logic [7:0] INDEX_RESET_VALUE  = 8'h40;
  localparam logic [7:0] INIT_READ_VALUE    = 8'h80;
  // indirect register numbers that matter here
  localparam logic [3:0] IND_LEFT_OUT       = 4'h6;
  localparam logic [3:0] IND_RIGHT_OUT      = 4'h7;
  localparam logic [3:0] IND_CLK_FORMAT     = 4'h8;
  localparam logic [3:0] IND_IFACE_CFG      = 4'h9;
  localparam logic [3:0] IND_PIN_CTRL       = 4'hA;
  localparam logic [3:0] IND_TEST_INIT      = 4'hB;
  localparam int         NUM_INDIRECT       = 16;
  // indirect field positions
  localparam int         PEN_BIT            = 0;
  localparam int         CEN_BIT            = 1;
  localparam int         MUTE_BIT           = 7;
  localparam int         IEN_BIT            = 1;
  localparam int         ACI_BIT            = 5;
  localparam logic [7:0] ENABLE_MASK        = 8'h03;
  // status_flags fields
  localparam int         ST_INT_BIT         = 0;
  localparam int         ST_PLAY_READY_FLAG_BIT        = 1;
  localparam int         ST_PLR_BIT         = 2;
  // timing in sample periods, and the DAC midscale code
  localparam int         SETTLE_SAMPLES     = 128;
  localparam logic [7:0] SETTLE_COUNT       = 8'(SETTLE_SAMPLES);
  localparam logic [15:0] MIDSCALE          = 16'h0000;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] host_reg_select;
    logic [7:0] wdata;
  } cdrp_host_s;

  typedef struct packed {
    logic play_dma_request;
    logic capture_dma_request;
    logic counter_decrement;
    logic left_dac_mute;
    logic right_dac_mute;
    logic adc_mute;
  } cdrp_ctl_s;
endpackage

// file: hw/cdrp_top.sv
// direct register port of the stereo codec: index, indexed window and status
// Summary of operation
// - four-bit read/write index pointer selects the indirect register reached via window
// - hold bit clear: requests follow enables, counter decrements each sample if enabled
// - hold bit set: request only while enabled and interrupt flag is 0 or a transfer is pending
// - on hold, pending requests finish, then DACs get midscale, ADC keeps last
// - clearing interrupt flag or hold bit resumes requests for enabled directions
// - counter stops while both hold bit and interrupt flag are one
// - format and interface registers locked unless unlock set, except enable bits
// - DACs muted while unlock set, then follow left and right mute bits
// - after unlock exit all converters muted for 128 samples, still running
// - every unlock exit sets calibration flag for the settling interval
// - read-only initialization flag in index bit 7 while bus cannot respond
// - index register reads 40h after reset and after initialization ends
// - during initialization index writes ignored and reads return 80h
// - window reads and writes reach the selected eight-bit indirect register
// - during initialization window writes ignored and reads return 80h
// - interrupt flag is the only sticky bit, others refresh each sample
// - two-bit host select picks direct register; 3 is PIO data
`timescale 1ns/1ps
`default_nettype none
module cdrp_top #(
  parameter int SETTLE_SAMPLES_P = cdrp_pkg::SETTLE_SAMPLES
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire cdrp_pkg::cdrp_host_s host_req,
  input  wire logic                init_active,
  input  wire logic                sample_tick,
  input  wire logic                irq_event,
  input  wire logic                play_pending,
  input  wire logic                capture_pending,
  input  wire logic                play_sample_stale,
  input  wire logic                play_next_is_left,
  output logic [7:0]               host_rdata,
  output cdrp_pkg::cdrp_ctl_s      ctl,
  output logic                     irq_pin,
  output logic                     dac_midscale,
  output logic                     adc_hold_last,
  output logic                     calib_in_progress,
  output logic                     pio_play_write,
  output logic                     pio_capture_read
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic [3:0]  index_pointer_reg,     index_pointer_next;
  logic        hold_reg,              hold_next;
  logic        unlock_reg,            unlock_next;
  logic        irq_flag_reg,          irq_flag_next;
  logic        play_ready_flag_reg,              play_ready_flag_next;
  logic        plr_reg,               plr_next;
  logic [7:0]  settle_reg,            settle_next;
  logic        calib_reg,             calib_next;
  logic        init_seen_reg,         init_seen_next;
  logic [7:0]  rdata_reg,             rdata_next;
  cdrp_pkg::cdrp_ctl_s ctl_reg,       ctl_next;
  logic        irq_pin_reg,           irq_pin_next;
  logic        midscale_reg,          midscale_next;
  logic        adc_hold_reg,          adc_hold_next;
  logic        pwr_reg,               pwr_next;
  logic        crd_reg,               crd_next;
  logic [7:0]  indirect_reg [cdrp_pkg::NUM_INDIRECT];
  logic [7:0]  indirect_next [cdrp_pkg::NUM_INDIRECT];

  function automatic logic is_locked(input logic [3:0] idx);
    is_locked = (idx == cdrp_pkg::IND_CLK_FORMAT) || (idx == cdrp_pkg::IND_IFACE_CFG);
  endfunction

  logic        wr_access;
  logic        rd_access;
  logic        play_en;
  logic        cap_en;
  logic        xfer_held;
  logic        settling;
  logic [7:0]  index_view;
  logic [7:0]  status_view;
  logic [7:0]  window_view;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    wr_access = host_req.wr;
    rd_access = host_req.rd;
    play_en   = indirect_reg[cdrp_pkg::IND_IFACE_CFG][cdrp_pkg::PEN_BIT];
    cap_en    = indirect_reg[cdrp_pkg::IND_IFACE_CFG][cdrp_pkg::CEN_BIT];
    xfer_held = hold_reg && irq_flag_reg;
    settling  = (settle_reg != 8'h00);

    index_pointer_next = index_pointer_reg;
    hold_next          = hold_reg;
    unlock_next        = unlock_reg;
    irq_flag_next      = irq_flag_reg;
    settle_next        = settle_reg;
    calib_next         = settling;
    init_seen_next     = init_active;
    for (int i = 0; i < cdrp_pkg::NUM_INDIRECT; i++) begin
      indirect_next[i] = indirect_reg[i];
    end

    // leaving initialization restores the power-up index value
    if (init_seen_reg && !init_active) begin
      index_pointer_next = cdrp_pkg::INDEX_RESET_VALUE[3:0];
      hold_next          = cdrp_pkg::INDEX_RESET_VALUE[cdrp_pkg::IDX_TRD_BIT];
      unlock_next        = cdrp_pkg::INDEX_RESET_VALUE[cdrp_pkg::IDX_MCE_BIT];
    end

    // decrement first so that a fresh load below wins on a tick
    if (sample_tick && settling) begin
      settle_next = settle_reg - 8'h01;
    end

    // a status write clears the flag even during initialization
    if (wr_access && host_req.host_reg_select == cdrp_pkg::REG_STATUS_FLAGS) begin
      irq_flag_next = 1'b0;
    end

    if (wr_access && !init_active) begin
      unique case (host_req.host_reg_select)
        cdrp_pkg::REG_INDEX_CONTROL: begin
          index_pointer_next = host_req.wdata[3:0];
          hold_next          = host_req.wdata[cdrp_pkg::IDX_TRD_BIT];
          unlock_next        = host_req.wdata[cdrp_pkg::IDX_MCE_BIT];
          // unlock falling starts settling and calibration
          if (unlock_reg && !host_req.wdata[cdrp_pkg::IDX_MCE_BIT]) begin
            settle_next = 8'(SETTLE_SAMPLES_P);
          end
        end
        cdrp_pkg::REG_INDEXED_WINDOW: begin
          if (!is_locked(index_pointer_reg) || unlock_reg) begin
            indirect_next[index_pointer_reg] = host_req.wdata;
          end else if (index_pointer_reg == cdrp_pkg::IND_IFACE_CFG) begin
            indirect_next[index_pointer_reg] =
              (indirect_reg[index_pointer_reg] & ~cdrp_pkg::ENABLE_MASK) |
              (host_req.wdata & cdrp_pkg::ENABLE_MASK);
          end
        end
        cdrp_pkg::REG_STATUS_FLAGS: begin
        end
        cdrp_pkg::REG_PIO_DATA: begin
        end
      endcase
    end

    // set wins over the clear of the same cycle
    if (irq_event) begin
      irq_flag_next = 1'b1;
    end

  end

  // --------------------------------------------------------------------------
  // outputs and read data
  // --------------------------------------------------------------------------
  always_comb begin
    index_view = {1'b0, unlock_reg, hold_reg, 1'b0, index_pointer_reg};
    status_view = 8'h00;
    status_view[cdrp_pkg::ST_INT_BIT]  = irq_pin_reg;
    status_view[cdrp_pkg::ST_PLAY_READY_FLAG_BIT] = play_ready_flag_reg;
    status_view[cdrp_pkg::ST_PLR_BIT]  = plr_reg;
    window_view = indirect_reg[index_pointer_reg];
    if (index_pointer_reg == cdrp_pkg::IND_TEST_INIT) begin
      window_view[cdrp_pkg::ACI_BIT] = calib_reg;
    end

    // status bits other than the interrupt refresh once per sample
    play_ready_flag_next = sample_tick ? play_sample_stale : play_ready_flag_reg;
    plr_next  = sample_tick ? play_next_is_left : plr_reg;

    rdata_next = rdata_reg;
    if (rd_access) begin
      if (init_active && host_req.host_reg_select != cdrp_pkg::REG_STATUS_FLAGS) begin
        rdata_next = cdrp_pkg::INIT_READ_VALUE;
      end else begin
        unique case (host_req.host_reg_select)
          cdrp_pkg::REG_INDEX_CONTROL:  rdata_next = index_view;
          cdrp_pkg::REG_INDEXED_WINDOW: rdata_next = window_view;
          cdrp_pkg::REG_STATUS_FLAGS:   rdata_next = status_view;
          cdrp_pkg::REG_PIO_DATA:       rdata_next = rdata_reg;
        endcase
      end
    end

    // a pending request finishes even once transfers become held
    ctl_next.play_dma_request    = play_en && (!xfer_held || play_pending);
    ctl_next.capture_dma_request = cap_en && (!xfer_held || capture_pending);
    ctl_next.counter_decrement   = sample_tick && (play_en || cap_en) && !xfer_held;
    ctl_next.left_dac_mute  = unlock_reg || settling ||
                              indirect_reg[cdrp_pkg::IND_LEFT_OUT][cdrp_pkg::MUTE_BIT];
    ctl_next.right_dac_mute = unlock_reg || settling ||
                              indirect_reg[cdrp_pkg::IND_RIGHT_OUT][cdrp_pkg::MUTE_BIT];
    ctl_next.adc_mute       = settling;
    irq_pin_next  = irq_flag_next &&
                    indirect_reg[cdrp_pkg::IND_PIN_CTRL][cdrp_pkg::IEN_BIT];
    midscale_next = xfer_held && !play_pending;
    adc_hold_next = xfer_held && !capture_pending;
    pwr_next = wr_access && !init_active && host_req.host_reg_select == cdrp_pkg::REG_PIO_DATA;
    crd_next = rd_access && !init_active && host_req.host_reg_select == cdrp_pkg::REG_PIO_DATA;
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_pointer_reg <= cdrp_pkg::INDEX_RESET_VALUE[3:0];
      hold_reg          <= cdrp_pkg::INDEX_RESET_VALUE[cdrp_pkg::IDX_TRD_BIT];
      unlock_reg        <= cdrp_pkg::INDEX_RESET_VALUE[cdrp_pkg::IDX_MCE_BIT];
      irq_flag_reg      <= 1'b0;
      play_ready_flag_reg          <= 1'b0;
      plr_reg           <= 1'b0;
      settle_reg        <= 8'h00;
      calib_reg         <= 1'b0;
      init_seen_reg     <= 1'b0;
      rdata_reg         <= 8'h00;
      ctl_reg           <= '0;
      irq_pin_reg       <= 1'b0;
      midscale_reg      <= 1'b0;
      adc_hold_reg      <= 1'b0;
      pwr_reg           <= 1'b0;
      crd_reg           <= 1'b0;
      for (int i = 0; i < cdrp_pkg::NUM_INDIRECT; i++) begin
        indirect_reg[i] <= 8'h00;
      end
    end else begin
      index_pointer_reg <= index_pointer_next;
      hold_reg          <= hold_next;
      unlock_reg        <= unlock_next;
      irq_flag_reg      <= irq_flag_next;
      play_ready_flag_reg          <= play_ready_flag_next;
      plr_reg           <= plr_next;
      settle_reg        <= settle_next;
      calib_reg         <= calib_next;
      init_seen_reg     <= init_seen_next;
      rdata_reg         <= rdata_next;
      ctl_reg           <= ctl_next;
      irq_pin_reg       <= irq_pin_next;
      midscale_reg      <= midscale_next;
      adc_hold_reg      <= adc_hold_next;
      pwr_reg           <= pwr_next;
      crd_reg           <= crd_next;
      for (int i = 0; i < cdrp_pkg::NUM_INDIRECT; i++) begin
        indirect_reg[i] <= indirect_next[i];
      end
    end
  end

  assign host_rdata        = rdata_reg;
  assign ctl               = ctl_reg;
  assign irq_pin           = irq_pin_reg;
  assign dac_midscale      = midscale_reg;
  assign adc_hold_last     = adc_hold_reg;
  assign calib_in_progress = calib_reg;
  assign pio_play_write    = pwr_reg;
  assign pio_capture_read  = crd_reg;

endmodule
`default_nettype wire

// file: dv/cdrp_assertions.sv
// checker: port assertions of the codec direct register port
`timescale 1ns/1ps
`default_nettype none
module cdrp_assertions #(
  parameter int SETTLE_SAMPLES_P = 128
) (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire cdrp_pkg::cdrp_host_s host_req,
  input wire logic                 init_active,
  input wire logic                 sample_tick,
  input wire logic                 irq_event,
  input wire logic                 play_sample_stale,
  input wire logic                 play_next_is_left,
  input wire logic [7:0]           host_rdata,
  input wire cdrp_pkg::cdrp_ctl_s  ctl,
  input wire logic                 irq_pin,
  input wire logic                 calib_in_progress,
  input wire logic                 pio_play_write,
  input wire logic                 pio_capture_read
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // shadow of unlock bit and sampled status levels
  // ------------------------------------------------------------
  logic mce_q;
  logic init_q;
  logic stale_q;
  logic left_q;
  wire  wr_idx = host_req.wr && host_req.host_reg_select == 2'h0 && !init_active;
  wire  sel_st = host_req.host_reg_select == 2'h2;
  wire  sel_io = host_req.host_reg_select == 2'h3;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mce_q   <= 1'b1;
      init_q  <= 1'b0;
      stale_q <= 1'b0;
      left_q  <= 1'b0;
    end else begin
      init_q  <= init_active;
      mce_q   <= wr_idx ? host_req.wdata[6] : (init_q && !init_active) ? 1'b1 : mce_q;
      stale_q <= sample_tick ? play_sample_stale : stale_q;
      left_q  <= sample_tick ? play_next_is_left : left_q;
    end
  end
  chk_init_read: assert property (
    host_req.rd && init_active && !sel_st |=> host_rdata == 8'h80) else $error("init read not 80h");
  chk_status_clear: assert property (
    host_req.wr && sel_st && !irq_event ##1 !irq_event |-> ##1 !irq_pin) else $error("irq not cleared");
  chk_dec_tick: assert property (
    ctl.counter_decrement |-> $past(sample_tick)) else $error("decrement without tick");
  chk_pio_write: assert property (
    host_req.wr && sel_io && !init_active |=> pio_play_write) else $error("no play write pulse");
  chk_pio_read: assert property (
    host_req.rd && sel_io && !init_active |=> pio_capture_read) else $error("no capture read pulse");
  chk_calib_start: assert property (
    wr_idx && mce_q && !host_req.wdata[6] |-> ##2 calib_in_progress [*2]) else $error("calib flag not set");
  chk_unlock_mute: assert property (
    mce_q && $past(mce_q) && $past(mce_q, 2) && $past(reset_n, 2) |-> ctl.left_dac_mute && ctl.right_dac_mute)
    else $error("dac not muted");
  chk_status_bits: assert property (
    host_req.rd && sel_st |=> host_rdata[2:1] == $past({left_q, stale_q})) else $error("status bits wrong");
  cov_calib: cover property (calib_in_progress && ctl.adc_mute);
  cov_pio: cover property (host_req.wr && sel_io);
  cov_held: cover property ($fell(ctl.play_dma_request));
endmodule
bind cdrp_top cdrp_assertions #(.SETTLE_SAMPLES_P(SETTLE_SAMPLES_P)) u_cdrp_assertions (.sys_clk, .reset_n,
  .host_req, .init_active, .sample_tick, .irq_event, .play_sample_stale, .play_next_is_left, .host_rdata,
  .ctl, .irq_pin, .calib_in_progress, .pio_play_write, .pio_capture_read);
`default_nettype wire

// file: dv/cdrp_dma_model.sv
// dma controller model: answers each request with a short busy burst
`timescale 1ns/1ps
`default_nettype none
module cdrp_dma_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic play_req,
  input  wire logic capture_req,
  output logic      play_pending,
  output logic      capture_pending
);
  // a burst runs to its end even if the request drops, like a granted cycle
  logic [2:0] p_cnt = 3'h0;
  logic [2:0] c_cnt = 3'h0;
  always @(negedge sys_clk) begin
    p_cnt <= !reset_n ? 3'h0 : (play_req || p_cnt != 3'h0) ? p_cnt + 3'h1 : p_cnt;
    c_cnt <= !reset_n ? 3'h0 : (capture_req || c_cnt != 3'h0) ? c_cnt + 3'h3 : c_cnt;
  end
  assign play_pending    = p_cnt[2];
  assign capture_pending = c_cnt[2];
endmodule
`default_nettype wire

// file: dv/tb_cdrp_top.sv
// testbench of the codec direct register port
`timescale 1ns/1ps
`default_nettype none
module tb_cdrp_top;
  logic                 sys_clk = 1'b0;
  logic                 reset_n = 1'b0;
  cdrp_pkg::cdrp_host_s host_req = '0;
  logic                 init_active = 1'b0;
  logic                 sample_tick = 1'b0;
  logic                 irq_event = 1'b0;
  logic                 stale = 1'b0;
  logic                 left = 1'b0;
  logic                 play_pending;
  logic                 capture_pending;
  logic [7:0]           host_rdata;
  cdrp_pkg::cdrp_ctl_s  ctl;
  logic                 irq_pin;
  logic                 dac_midscale;
  logic                 adc_hold_last;
  logic                 calib;
  logic                 pio_wr;
  logic                 pio_rd;
  int                   errors = 0;
  int                   cmp_count = 0;
  int                   n;
  localparam int SETTLE = 4;
  cdrp_top #(.SETTLE_SAMPLES_P(SETTLE)) u_cdrp_top (.sys_clk, .reset_n, .host_req, .init_active, .sample_tick,
    .irq_event, .play_pending, .capture_pending, .play_sample_stale(stale), .play_next_is_left(left), .host_rdata,
    .ctl, .irq_pin, .dac_midscale, .adc_hold_last, .calib_in_progress(calib), .pio_play_write(pio_wr),
    .pio_capture_read(pio_rd));
  cdrp_dma_model u_cdrp_dma_model (.sys_clk, .reset_n, .play_req(ctl.play_dma_request),
    .capture_req(ctl.capture_dma_request), .play_pending, .capture_pending);
  // ------------------------------------------------------------
  // clock, sample ticks, bus tasks
  // ------------------------------------------------------------
  initial forever #12.5 sys_clk = ~sys_clk;
  initial forever begin
    repeat (7) @(negedge sys_clk);
    sample_tick = 1'b1;
    @(negedge sys_clk);
    sample_tick = 1'b0;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(input logic r, input logic [1:0] sel, input logic [7:0] d);
    @(negedge sys_clk);
    host_req = '{rd: r, wr: !r, host_reg_select: sel, wdata: d};
    @(negedge sys_clk);
    host_req.rd = 1'b0;
    host_req.wr = 1'b0;
  endtask
  task automatic count_dec();
    n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (ctl.counter_decrement === 1'b1) n++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(25ns * 20000);
    errors++;
    conclude();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    access(1, 2'h0, 8'h00);
    check("index reset", host_rdata, 8'h40);
    access(0, 2'h0, 8'h48); // unlock first, reserved bit zero
    access(0, 2'h1, 8'h5A);
    access(1, 2'h1, 8'h00);
    check("format unlocked", host_rdata, 8'h5A);
    access(0, 2'h0, 8'h4A);
    access(0, 2'h1, 8'h02);
    access(0, 2'h0, 8'h08); // leave mode change
    @(negedge sys_clk); // flag and mutes follow the settling count one cycle later
    check("calib set", calib, 8'h1);
    check("adc settle mute", ctl.adc_mute, 8'h1);
    check("dac settle mute", ctl.right_dac_mute, 8'h1);
    repeat (8 * SETTLE + 16) @(negedge sys_clk);
    check("calib done", calib, 8'h0);
    check("dac unmuted", ctl.left_dac_mute, 8'h0);
    access(0, 2'h1, 8'hA5);
    access(1, 2'h1, 8'h00);
    check("format locked", host_rdata, 8'h5A);
    access(1, 2'h0, 8'h00);
    check("index pointer", host_rdata, 8'h08);
    $display("test mode change done");
    access(0, 2'h0, 8'h09);
    access(0, 2'h1, 8'h03);
    access(1, 2'h1, 8'h00);
    check("enables on the fly", host_rdata, 8'h03);
    count_dec();
    check("decrements", 8'(n), 8'h5);
    check("play request", ctl.play_dma_request, 8'h1);
    access(0, 2'h0, 8'h29);
    irq_event = 1'b1;
    @(negedge sys_clk);
    irq_event = 1'b0;
    repeat (24) @(negedge sys_clk); // let any granted burst run out
    repeat (4) @(negedge sys_clk);
    check("irq pin", irq_pin, 8'h1);
    check("play held", ctl.play_dma_request, 8'h0);
    check("capture held", ctl.capture_dma_request, 8'h0);
    check("dac midscale", dac_midscale, 8'h1);
    check("adc hold", adc_hold_last, 8'h1);
    access(1, 2'h2, 8'h00);
    check("status int", host_rdata[0], 8'h1);
    count_dec();
    check("no decrements", 8'(n), 8'h0);
    check("irq sticky", irq_pin, 8'h1);
    access(0, 2'h2, 8'h00);
    repeat (4) @(negedge sys_clk);
    check("irq cleared", irq_pin, 8'h0);
    check("play resumed", ctl.play_dma_request, 8'h1);
    $display("test hold done");
    stale = 1'b1;
    left = 1'b1;
    repeat (12) @(negedge sys_clk);
    access(1, 2'h2, 8'h00);
    check("play flags set", host_rdata[2:1], 8'h3);
    stale = 1'b0;
    left = 1'b0;
    repeat (12) @(negedge sys_clk);
    access(1, 2'h2, 8'h00);
    check("play flags clear", host_rdata[2:1], 8'h0);
    access(0, 2'h3, 8'h11);
    check("pio write pulse", pio_wr, 8'h1);
    access(1, 2'h3, 8'h00);
    check("pio read pulse", pio_rd, 8'h1);
    $display("test status done");
    init_active = 1'b1;
    access(0, 2'h0, 8'h03);
    access(0, 2'h1, 8'hFF);
    access(1, 2'h0, 8'h00);
    check("index init", host_rdata, 8'h80);
    access(1, 2'h1, 8'h00);
    check("window init", host_rdata, 8'h80);
    init_active = 1'b0;
    repeat (2) @(negedge sys_clk);
    access(1, 2'h0, 8'h00);
    check("index after init", host_rdata, 8'h40);
    access(0, 2'h0, 8'h49);
    access(1, 2'h1, 8'h00);
    check("window write ignored", host_rdata, 8'h03);
    $display("test init done");
    conclude();
  end
endmodule
`default_nettype wire
